//--- tb/frame_timing_tb_top.sv
// testbench of frame_timing: register map, frame timer and frame start handshake
// assumes the bench alone drives every input of the block
`timescale 1ns/1ps
`default_nettype none
module frame_timing_tb_top;
    import frame_timing_pkg::*;

    logic        clock;
    logic        srst;
    logic        clock_en;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    logic        sof_req;
    logic        sof_done;
    logic        comm_wr_valid;
    logic [15:0] comm_wr_data;
    logic        comm_wr_ready;
    logic        ed_fetch_go;
    logic        budget_use;
    logic [14:0] budget_left;
    logic        operational;
    logic        irq;
    int          fails;
    int          check_count;
    logic [31:0] rv;
    logic [31:0] r1;

    frame_timing u_dut (
        .clock         (clock),
        .srst          (srst),
        .clock_en      (clock_en),
        .addr          (addr),
        .wdata         (wdata),
        .wr_stb        (wr_stb),
        .rd_stb        (rd_stb),
        .rdata         (rdata),
        .sof_req       (sof_req),
        .sof_done      (sof_done),
        .comm_wr_valid (comm_wr_valid),
        .comm_wr_data  (comm_wr_data),
        .comm_wr_ready (comm_wr_ready),
        .ed_fetch_go   (ed_fetch_go),
        .budget_use    (budget_use),
        .budget_left   (budget_left),
        .operational   (operational),
        .irq           (irq)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [31:0] a);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        @(posedge clock);
        rv = rdata;
    endtask

    // bounded wait for sof_req (0) or comm_wr_valid (1)
    task automatic await(input int sel);
        int k;
        k = 0;
        while ((sel == 0 ? sof_req : comm_wr_valid) !== 1'b1) begin
            if (k == 3000) begin
                fails++;
                close_out();
            end
            @(posedge clock);
            k++;
        end
    endtask

    // one frame start: budget, remaining, shared-area write, fetch release
    task automatic frame(input logic [15:0] n, input logic [31:0] rem, input bit use_rem);
        await(0);
        chk(32'(budget_left), 32'h0000_0005);
        if (use_rem) begin
            rd(TIME_LEFT_ADDR);
            chk(rv, rem);
        end
        sof_done <= 1'b1;
        @(posedge clock);
        sof_done <= 1'b0;
        await(1);
        chk(32'(comm_wr_data), 32'(n));
        chk(32'(sof_req), 32'h0000_0000);
        chk(32'(ed_fetch_go), 32'h0000_0000);
        comm_wr_ready <= 1'b1;
        @(posedge clock);
        comm_wr_ready <= 1'b0;
        @(posedge clock);
        chk(32'(ed_fetch_go), 32'h0000_0001);
        chk(32'(comm_wr_valid), 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst          = 1'b1;
        clock_en      = 1'b1;
        addr          = 32'h0000_0000;
        wdata         = 32'h0000_0000;
        wr_stb        = 1'b0;
        rd_stb        = 1'b0;
        sof_done      = 1'b0;
        comm_wr_ready = 1'b0;
        budget_use    = 1'b0;
        fails         = 0;
        check_count   = 0;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rd(FRAME_CFG_ADDR);
        chk(rv, 32'h0000_2EDF);
        rd(TIME_LEFT_ADDR);
        chk(rv, 32'h0000_0000);
        rd(FRAME_CNT_ADDR);
        chk(rv, 32'h0000_0000);
        rd(32'h3000_2C50);
        chk(rv, 32'h0000_0000);
        wr(TIME_LEFT_ADDR, 32'hFFFF_FFFF);
        wr(FRAME_CNT_ADDR, 32'hFFFF_FFFF);
        rd(TIME_LEFT_ADDR);
        chk(rv, 32'h0000_0000);
        rd(FRAME_CNT_ADDR);
        chk(rv, 32'h0000_0000);
        // toggle set with the new length, reserved bits written high
        wr(FRAME_CFG_ADDR, 32'h8005_C064);
        rd(FRAME_CFG_ADDR);
        chk(rv, 32'h8005_0064);
        wr(IRQ_EN_ADDR, 32'h0000_0001);
        wr(CTRL_ADDR, 32'h0000_0001);
        chk(32'(operational), 32'h0000_0001);
        frame(16'h0001, 32'h0000_0000, 1'b0);
        rd(IRQ_STAT_ADDR);
        chk(rv, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        wr(IRQ_CLR_ADDR, 32'h0000_0001);
        rd(IRQ_STAT_ADDR);
        chk(rv, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        wr(IRQ_EN_ADDR, 32'h0000_0000);
        // 125 clocks hold exactly 12 bit times
        rd(TIME_LEFT_ADDR);
        r1 = rv;
        budget_use <= 1'b1;
        repeat (60) @(posedge clock);
        // 40 frozen clocks in between must not count
        clock_en   <= 1'b0;
        repeat (40) @(posedge clock);
        clock_en   <= 1'b1;
        repeat (63) @(posedge clock);
        rd(TIME_LEFT_ADDR);
        chk(32'(r1[13:0] - rv[13:0]), 32'h0000_000C);
        chk(32'(budget_left), 32'h0000_0000);
        budget_use <= 1'b0;
        wr(FRAME_CFG_ADDR, 32'h0005_0032);
        frame(16'h0002, 32'h0000_0032, 1'b1);
        rd(FRAME_CNT_ADDR);
        chk(rv, 32'h0000_0002);
        rd(IRQ_STAT_ADDR);
        chk(rv, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        wr(FRAME_CFG_ADDR, 32'h8005_0032);
        frame(16'h0003, 32'h8000_0032, 1'b1);
        // keep the tuned length across the soft reset
        rd(FRAME_CFG_ADDR);
        r1 = rv;
        wr(CTRL_ADDR, 32'h0000_0002);
        rd(FRAME_CFG_ADDR);
        chk(rv & 32'h0000_3FFF, 32'h0000_2EDF);
        chk(32'(operational), 32'h0000_0000);
        wr(FRAME_CFG_ADDR, r1);
        rd(FRAME_CFG_ADDR);
        chk(rv, 32'h8005_0032);
        // second reset in mid-run
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rd(TIME_LEFT_ADDR);
        chk(rv, 32'h0000_0000);
        rd(FRAME_CFG_ADDR);
        chk(rv, 32'h0000_2EDF);
        close_out();
    end
endmodule
`default_nettype wire

//--- verilog/bit_tick_gen.sv
// bit_tick_gen: one-cycle pulse at the USB bit rate from the system clock
// assumes clock_en freezes it along with the rest of the block
`timescale 1ns/1ps
`default_nettype none
module bit_tick_gen
    import frame_timing_pkg::*;
(
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic clock_en,
    output logic      tick
);
    typedef struct packed {
        logic [6:0] acc;
    } tick_s;

    tick_s      st_q;
    tick_s      st_d;
    logic [7:0] sum;

    // fractional accumulator, step over modulus gives the bit rate
    always_comb begin
        st_d = st_q;
        sum  = {1'b0, st_q.acc} + {1'b0, TICK_STEP};
        tick = clock_en && (sum >= {1'b0, TICK_MOD});
        if (sum >= {1'b0, TICK_MOD}) begin
            st_d.acc = 7'(sum - {1'b0, TICK_MOD});
        end else begin
            st_d.acc = sum[6:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= '0;
        end else if (clock_en) begin
            st_q <= st_d;
        end
    end
endmodule
`default_nettype wire

//--- verilog/frame_timing.sv
// frame_timing: frame length, remaining-time and frame count of the host
// assumes same-clock handshake partners for frame start and shared-area write
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module frame_timing
    import frame_timing_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        clock_en,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    output logic             sof_req,
    input  wire logic        sof_done,
    output logic             comm_wr_valid,
    output logic      [15:0] comm_wr_data,
    input  wire logic        comm_wr_ready,
    output logic             ed_fetch_go,
    input  wire logic        budget_use,
    output logic      [14:0] budget_left,
    output logic             operational,
    output logic             irq
);
    import frame_timing_pkg::*;

    typedef struct packed {
        frame_step_e step;
        logic        oper;
        logic [13:0] length;
        logic [14:0] budget_cfg;
        logic        itog;
        logic [13:0] remain;
        logic        rtog;
        logic [15:0] count;
        logic [14:0] budget;
        logic [1:0]  istat;
        logic [1:0]  ien;
        logic [31:0] rdata;
        logic        fetch_go;
        logic        irq;
    } state_s;

    state_s st_q;
    state_s st_d;
    logic   tick;
    logic   soft_rst;
    logic   enter_oper;
    logic   reload;

    ////////////////////////////////////////////////////////////////////////////
    // bit-time tick

    bit_tick_gen u_tick (
        .clock    (clock),
        .srst     (srst),
        .clock_en (clock_en),
        .tick     (tick)
    );

    function automatic logic hit(input logic [31:0] a);
        hit = wr_stb && (addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        st_d       = st_q;
        soft_rst   = hit(CTRL_ADDR) && wdata[CTRL_SRST_BIT];
        enter_oper = hit(CTRL_ADDR) && wdata[CTRL_OPER_BIT] && !st_q.oper && !soft_rst;
        reload     = st_q.oper && tick && (st_q.remain == REMAIN_RESET);
        st_d.fetch_go = 1'b0;

        // register reads, answered one cycle later
        st_d.rdata = 32'h0000_0000;
        if (rd_stb) begin
            unique case (addr)
                FRAME_CFG_ADDR: st_d.rdata = {st_q.itog, st_q.budget_cfg, 2'b00, st_q.length};
                TIME_LEFT_ADDR: st_d.rdata = {st_q.rtog, 17'h00000, st_q.remain};
                FRAME_CNT_ADDR: st_d.rdata = {16'h0000, st_q.count};
                CTRL_ADDR:      st_d.rdata = {31'h0000_0000, st_q.oper};
                IRQ_STAT_ADDR:  st_d.rdata = {30'h0000_0000, st_q.istat};
                IRQ_EN_ADDR:    st_d.rdata = {30'h0000_0000, st_q.ien};
                default:        st_d.rdata = 32'h0000_0000;
            endcase
        end

        // software writes; budget and toggle are only stored here
        if (hit(FRAME_CFG_ADDR)) begin
            st_d.itog       = wdata[TOGGLE_BIT];
            st_d.budget_cfg = wdata[BUDGET_MSB:BUDGET_LSB];
            st_d.length     = wdata[LENGTH_MSB:0];
        end
        if (hit(IRQ_EN_ADDR)) begin
            st_d.ien = wdata[1:0];
        end
        if (hit(CTRL_ADDR) && !wdata[CTRL_OPER_BIT]) begin
            st_d.oper = 1'b0;
        end

        // frame counting
        if (enter_oper) begin
            st_d.oper   = 1'b1;
            st_d.remain = st_q.length;
            st_d.rtog   = st_q.itog;
            st_d.count  = st_q.count + 16'h0001;
            st_d.budget = st_q.budget_cfg;
            st_d.step   = FT_SOF;
        end else if (reload) begin
            st_d.remain = st_q.length;
            st_d.rtog   = st_q.itog;
            st_d.count  = st_q.count + 16'h0001;
            st_d.budget = st_q.budget_cfg;
            st_d.step   = FT_SOF;
        end else if (st_q.oper && tick) begin
            st_d.remain = st_q.remain - 14'h0001;
            if (budget_use && st_q.budget != BUDGET_RESET) begin
                st_d.budget = st_q.budget - 15'h0001;
            end
        end

        // frame start sequence: send start packet, then shared-area write
        unique case (st_q.step)
            FT_RUN: begin
            end
            FT_SOF: begin
                if (sof_done) begin
                    st_d.step = FT_WRITE;
                end
            end
            FT_WRITE: begin
                if (comm_wr_ready) begin
                    st_d.step     = FT_RUN;
                    st_d.fetch_go = 1'b1;
                end
            end
            default: st_d.step = FT_RUN;
        endcase

        // sticky flags: set wins over clear
        st_d.istat = st_q.istat & ~(hit(IRQ_CLR_ADDR) ? wdata[1:0] : 2'b00);
        if (st_q.step == FT_WRITE && comm_wr_ready) begin
            st_d.istat[IRQ_SOF_BIT] = 1'b1;
        end
        if ((reload || enter_oper) && st_q.count == COUNT_MAX) begin
            st_d.istat[IRQ_WRAP_BIT] = 1'b1;
        end
        st_d.irq = |(st_d.istat & st_d.ien);

        // soft reset restores nominal length and halts the frame timer
        if (soft_rst) begin
            st_d.length = LENGTH_NOMINAL;
            st_d.oper   = 1'b0;
            st_d.step   = FT_RUN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q            <= '0;
            st_q.step       <= FT_RUN;
            st_q.length     <= LENGTH_NOMINAL;
            st_q.budget_cfg <= BUDGET_RESET;
            st_q.remain     <= REMAIN_RESET;
            st_q.count      <= COUNT_RESET;
        end else if (clock_en) begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rdata         = st_q.rdata;
    assign sof_req       = (st_q.step == FT_SOF);
    assign comm_wr_valid = (st_q.step == FT_WRITE);
    assign comm_wr_data  = st_q.count;
    assign ed_fetch_go   = st_q.fetch_go;
    assign budget_left   = st_q.budget;
    assign operational   = st_q.oper;
    assign irq           = st_q.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    remain_dec_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && tick && st_q.oper && st_q.remain != REMAIN_RESET && !soft_rst
            && !hit(CTRL_ADDR))
        |=> st_q.remain == $past(st_q.remain) - 14'h0001)
        else $error("remaining count did not step down");

    remain_reload_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && reload && !soft_rst && !hit(CTRL_ADDR))
        |=> st_q.remain == $past(st_q.length) && st_q.step == FT_SOF)
        else $error("remaining count did not reload");

    toggle_copy_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && reload && !soft_rst && !hit(CTRL_ADDR))
        |=> st_q.rtog == $past(st_q.itog))
        else $error("remaining toggle not copied");

    count_step_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && reload && !soft_rst && !hit(CTRL_ADDR))
        |=> st_q.count == $past(st_q.count) + 16'h0001)
        else $error("frame count did not advance");

    oper_entry_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && enter_oper)
        |=> st_q.oper && st_q.count == $past(st_q.count) + 16'h0001
            && st_q.remain == $past(st_q.length))
        else $error("operational entry wrong");

    soft_reset_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && soft_rst) |=> st_q.length == LENGTH_NOMINAL && !st_q.oper)
        else $error("soft reset did not restore length");

    budget_load_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && (reload || enter_oper) && !soft_rst && !hit(FRAME_CFG_ADDR))
        |=> budget_left == $past(st_q.budget_cfg))
        else $error("packet budget not loaded");

    write_order_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && sof_req && sof_done && !soft_rst)
        |=> comm_wr_valid && comm_wr_data == $past(st_q.count))
        else $error("shared-area write out of order");

    sof_flag_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && comm_wr_valid && comm_wr_ready)
        |=> st_q.istat[IRQ_SOF_BIT] && ed_fetch_go)
        else $error("start-of-frame flag not set");

    reserved_zero_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && rd_stb && addr == TIME_LEFT_ADDR)
        |=> rdata[30:14] == 17'h00000)
        else $error("reserved bits not zero");

    reset_state_a: assert property (@(posedge clock)
        srst |=> st_q.remain == REMAIN_RESET && st_q.length == LENGTH_NOMINAL)
        else $error("reset values wrong");

    cfg_reserved_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && rd_stb && addr == FRAME_CFG_ADDR)
        |=> rdata[BUDGET_LSB-1:LENGTH_MSB+1] == '0)
        else $error("frame length reserved bits not zero");

    count_reserved_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && rd_stb && addr == FRAME_CNT_ADDR)
        |=> rdata[TOGGLE_BIT:COUNT_MSB+1] == '0)
        else $error("frame count reserved bits not zero");

    length_write_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && hit(FRAME_CFG_ADDR))
        |=> st_q.length == $past(wdata[LENGTH_MSB:0]))
        else $error("frame length not written");

    length_hold_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && !hit(FRAME_CFG_ADDR) && !soft_rst)
        |=> $stable(st_q.length))
        else $error("frame length changed unasked");

    budget_write_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && hit(FRAME_CFG_ADDR))
        |=> st_q.budget_cfg == $past(wdata[BUDGET_MSB:BUDGET_LSB]))
        else $error("packet budget field not written");

    toggle_write_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && hit(FRAME_CFG_ADDR))
        |=> st_q.itog == $past(wdata[TOGGLE_BIT]))
        else $error("interval toggle not written");

    toggle_hold_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && !reload && !enter_oper)
        |=> $stable(st_q.rtog))
        else $error("remaining toggle changed without reload");

    remain_idle_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && !st_q.oper && !enter_oper)
        |=> $stable(st_q.remain))
        else $error("remaining count moved while stopped");

    frozen_state_a: assert property (@(posedge clock) disable iff (srst)
        !clock_en
        |=> $stable(st_q))
        else $error("state moved while clock enable low");

    remain_ro_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && hit(TIME_LEFT_ADDR) && !tick)
        |=> $stable(st_q.remain))
        else $error("remaining count took a write");

    count_hold_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && !reload && !enter_oper)
        |=> $stable(st_q.count))
        else $error("frame count changed without reload");

    count_wrap_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && reload && st_q.count == COUNT_MAX)
        |=> st_q.count == COUNT_RESET)
        else $error("frame count did not wrap");

    oper_toggle_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && enter_oper)
        |=> st_q.rtog == $past(st_q.itog) && budget_left == $past(st_q.budget_cfg))
        else $error("operational entry did not load frame");

    budget_step_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && tick && st_q.oper && st_q.remain != REMAIN_RESET && budget_use
            && st_q.budget != BUDGET_RESET)
        |=> budget_left == $past(st_q.budget) - 15'h0001)
        else $error("packet budget did not step down");

    budget_floor_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && st_q.budget == BUDGET_RESET && !reload && !enter_oper)
        |=> budget_left == BUDGET_RESET)
        else $error("packet budget went below zero");

    budget_hold_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && !tick && !enter_oper)
        |=> $stable(st_q.budget))
        else $error("packet budget moved off a bit time");

    sof_hold_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && sof_req && !sof_done && !soft_rst)
        |=> sof_req)
        else $error("frame start request dropped");

    write_hold_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && comm_wr_valid && !comm_wr_ready && !reload && !hit(CTRL_ADDR))
        |=> comm_wr_valid && $stable(comm_wr_data))
        else $error("shared-area write dropped or changed");

    one_step_a: assert property (@(posedge clock) disable iff (srst)
        (sof_req || comm_wr_valid)
        |-> sof_req != comm_wr_valid)
        else $error("frame start steps overlap");

    fetch_after_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && !(comm_wr_valid && comm_wr_ready))
        |=> !ed_fetch_go)
        else $error("descriptor fetch before shared-area write");

    sof_flag_only_a: assert property (@(posedge clock) disable iff (srst)
        (clock_en && !st_q.istat[IRQ_SOF_BIT] && !(comm_wr_valid && comm_wr_ready))
        |=> !st_q.istat[IRQ_SOF_BIT])
        else $error("start-of-frame flag set too early");
endmodule
`default_nettype wire

//--- verilog/frame_timing_pkg.sv
// package: constants of the frame timing block
// assumes one 125 MHz clock and a plain strobe register port
//
// Overview of operation
// - each frame start loads the packet budget field into the largest-packet counter
// - frame length sits in bits 13:0 and resets to 11,999 bit times
// - a controller soft reset restores the frame length to its nominal value
// - remaining counter reaching zero copies the interval toggle into the remaining toggle
// - remaining counter decrements once per bit time
// - at zero the remaining counter reloads the frame length on next bit time
// - entering operational reloads remaining from frame length, used from next frame
// - remaining counter is 14-bit, reads zero after reset, read-only
// - 16-bit frame count increments on every reload and wraps after all ones
// - entering operational increments the frame count
// - frame count goes to the shared area after increment and frame start, before fetch
// - after that write the start-of-frame status flag is set
package frame_timing_pkg;
    localparam int          CLK_HZ          = 125_000_000;
    localparam int          BIT_HZ          = 12_000_000;
    localparam int          TICK_STEP_I     = BIT_HZ / 1_000_000;
    localparam int          TICK_MOD_I      = CLK_HZ / 1_000_000;
    localparam logic [6:0]  TICK_STEP       = 7'(TICK_STEP_I);
    localparam logic [6:0]  TICK_MOD        = 7'(TICK_MOD_I);

    localparam logic [31:0] FRAME_CFG_ADDR  = 32'h3000_2C34;
    localparam logic [31:0] TIME_LEFT_ADDR  = 32'h3000_2C38;
    localparam logic [31:0] FRAME_CNT_ADDR  = 32'h3000_2C3C;
    localparam logic [31:0] CTRL_ADDR       = 32'h3000_2C40;
    localparam logic [31:0] IRQ_STAT_ADDR   = 32'h3000_2C44;
    localparam logic [31:0] IRQ_CLR_ADDR    = 32'h3000_2C48;
    localparam logic [31:0] IRQ_EN_ADDR     = 32'h3000_2C4C;

    localparam int          TOGGLE_BIT      = 31;
    localparam int          BUDGET_LSB      = 16;
    localparam int          BUDGET_MSB      = 30;
    localparam int          LENGTH_MSB      = 13;
    localparam int          COUNT_MSB       = 15;
    localparam int          CTRL_OPER_BIT   = 0;
    localparam int          CTRL_SRST_BIT   = 1;
    localparam int          IRQ_SOF_BIT     = 0;
    localparam int          IRQ_WRAP_BIT    = 1;

    localparam logic [13:0] LENGTH_NOMINAL  = 14'h2EDF;
    localparam logic [14:0] BUDGET_RESET    = 15'h0000;
    localparam logic [13:0] REMAIN_RESET    = 14'h0000;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [15:0] COUNT_MAX       = 16'hFFFF;

    typedef enum logic [1:0] {
        FT_RUN   = 2'b00,
        FT_SOF   = 2'b01,
        FT_WRITE = 2'b10
    } frame_step_e;
endpackage
